// file: sysctl_defs.svh
// Constants for the system control block: offsets, fields, resets, counts
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

// ************************************************************
// Register placement
// ************************************************************
`define SYSCTL_INDEX 10'h035
`define SYSCTL_RESET 8'h00

// ************************************************************
// Field positions
// ************************************************************
`define BIT_DEBUG_DIS 7
`define BIT_BOD_SLP_DIS 6
`define BIT_BOD_SLP_UNL 5
`define BIT_PULLUP_DIS 4
`define BIT_VEC_SEL 1
`define BIT_VEC_UNLOCK 0

// ************************************************************
// Timing and bus answers
// ************************************************************
`define UNLOCK_CYCLES 3'd4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ************************************************************
// Vector bases (word address), boot start per fuse code
// ************************************************************
`define APP_VECTOR_BASE 16'h0000
`define BOOT_START_0 16'h1F00
`define BOOT_START_1 16'h1E00
`define BOOT_START_2 16'h1C00
`define BOOT_START_3 16'h1800

`endif

// file: sysctl_pkg.sv
// Types shared by the system control block
package sysctl_pkg;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ARMED = 2'b01,
      PH_HOLD = 2'b10
   } phase_e;
endpackage

// file: interrupt_vector_select_ctrl.sv
// System control register with guarded vector placement and interrupt masking
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module interrupt_vector_select_ctrl
   import sysctl_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // AXI4-Lite write
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [11:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // AXI4-Lite read
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [11:0] ARADDR,
   input wire logic [2:0] ARPROT,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // Core and configuration inputs
   input wire logic INSTR_RETIRE,
   input wire logic EXEC_IN_BOOT,
   input wire logic [1:0] BOOT_SIZE_FUSE,
   input wire logic APP_BOOT_LOCK,
   input wire logic BOOT_SECTION_LOCK,
   input wire logic BOD_SLEEP_DISABLE_ST,
   input wire logic BOD_SLEEP_UNLOCK_ST,
   // Outputs to core and pads
   output logic [15:0] VECTOR_BASE,
   output logic IRQ_MASK,
   output logic DEBUG_PORT_DISABLE,
   output logic PULLUP_GLOBAL_DISABLE
);

   // ************************************************************
   // State
   // ************************************************************
   logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
   logic [1:0] bresp_q;
   logic [11:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_strb_q;
   logic arready_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   phase_e phase_q, phase_d;
   logic [1:0] cnt_q, cnt_d;
   logic vsel_q, dbg_q, pullup_q;
   logic [15:0] base_q;
   logic mask_q;
   // Reset image of the register; fields are picked from it by position
   localparam logic [7:0] RESET_IMAGE = `SYSCTL_RESET;

   // ************************************************************
   // Write channel decode
   // ************************************************************
   wire aw_take = AWVALID & awready_q;
   wire w_take = WVALID & wready_q;
   wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
   wire aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
   wire w_full_d = (w_full_q | w_take) & ~wr_fire;
   wire bvalid_d = (bvalid_q & ~BREADY) | wr_fire;
   wire wr_hit = aw_addr_q[11:2] == `SYSCTL_INDEX;
   // Byte lane 0 only; other lanes hold nothing here
   wire wr_ok = wr_fire & wr_hit & w_strb_q;
   wire wr_unlk = w_data_q[`BIT_VEC_UNLOCK];
   wire wr_vsel = w_data_q[`BIT_VEC_SEL];
   wire unlock_q = phase_q == PH_ARMED;
   wire arm = wr_ok & wr_unlk;
   // Software owns the timing of the second write; we only honour it while armed
   wire commit = wr_ok & ~wr_unlk & unlock_q;
   wire vsel_d = commit ? wr_vsel : vsel_q;
   wire dbg_d = wr_ok ? w_data_q[`BIT_DEBUG_DIS] : dbg_q;
   wire pullup_d = wr_ok ? w_data_q[`BIT_PULLUP_DIS] : pullup_q;

   // ************************************************************
   // Read channel decode
   // ************************************************************
   wire ar_take = ARVALID & arready_q;
   wire rvalid_d = (rvalid_q & ~RREADY) | ar_take;
   wire rd_hit = ARADDR[11:2] == `SYSCTL_INDEX;
   wire [7:0] reg_view = {dbg_q, BOD_SLEEP_DISABLE_ST, BOD_SLEEP_UNLOCK_ST, pullup_q,
                          2'b00, vsel_q, unlock_q};
   wire [31:0] rdata_d = rd_hit ? {24'h000000, reg_view} : 32'h00000000;
   wire [1:0] rresp_d = rd_hit ? `RESP_OKAY : `RESP_SLVERR;

   // ************************************************************
   // Unlock sequencing
   // ************************************************************
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      case (phase_q)
         PH_IDLE: begin
            if (arm) begin
               phase_d = PH_ARMED;
               cnt_d = 2'(`UNLOCK_CYCLES - 3'd1);
            end
         end
         PH_ARMED: begin
            if (commit) begin
               phase_d = PH_HOLD;
            end else if (arm) begin
               cnt_d = 2'(`UNLOCK_CYCLES - 3'd1);
            end else if (cnt_q == 2'd0) begin
               phase_d = PH_IDLE;
            end else begin
               cnt_d = cnt_q - 2'd1;
            end
         end
         PH_HOLD: begin
            // The write itself has retired; the next retire is the following one
            if (arm) begin
               phase_d = PH_ARMED;
               cnt_d = 2'(`UNLOCK_CYCLES - 3'd1);
            end else if (INSTR_RETIRE) begin
               phase_d = PH_IDLE;
            end
         end
         default: begin
            phase_d = PH_IDLE;
            cnt_d = 2'd0;
         end
      endcase
   end

   // ************************************************************
   // Vector base and interrupt blocking
   // ************************************************************
   wire [15:0] boot_start = (BOOT_SIZE_FUSE == 2'd0) ? `BOOT_START_0 :
                            (BOOT_SIZE_FUSE == 2'd1) ? `BOOT_START_1 :
                            (BOOT_SIZE_FUSE == 2'd2) ? `BOOT_START_2 :
                            `BOOT_START_3;
   wire [15:0] base_d = vsel_d ? boot_start : `APP_VECTOR_BASE;
   wire seq_mask_d = phase_d != PH_IDLE;
   wire lock_app_d = vsel_d & APP_BOOT_LOCK & ~EXEC_IN_BOOT;
   wire lock_boot_d = ~vsel_d & BOOT_SECTION_LOCK & EXEC_IN_BOOT;
   // Separate mask line; the core's global enable bit is never written here
   wire mask_d = seq_mask_d | lock_app_d | lock_boot_d;

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge CLK) begin
      if (SRST) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         aw_addr_q <= 12'h000;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready_q <= ~aw_full_d;
         wready_q <= ~w_full_d;
         bvalid_q <= bvalid_d;
         if (wr_fire) begin
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (aw_take) begin
            aw_addr_q <= AWADDR;
         end
         if (w_take) begin
            w_data_q <= WDATA[7:0];
            w_strb_q <= WSTRB[0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_take) begin
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         phase_q <= PH_IDLE;
         cnt_q <= 2'd0;
         vsel_q <= RESET_IMAGE[`BIT_VEC_SEL];
         dbg_q <= RESET_IMAGE[`BIT_DEBUG_DIS];
         pullup_q <= RESET_IMAGE[`BIT_PULLUP_DIS];
         base_q <= `APP_VECTOR_BASE;
         mask_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         vsel_q <= vsel_d;
         dbg_q <= dbg_d;
         pullup_q <= pullup_d;
         base_q <= base_d;
         mask_q <= mask_d;
      end
   end

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;
   assign VECTOR_BASE = base_q;
   assign IRQ_MASK = mask_q;
   assign DEBUG_PORT_DISABLE = dbg_q;
   assign PULLUP_GLOBAL_DISABLE = pullup_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   arm_load_a: assert property (arm |=> unlock_q && cnt_q == 2'd3)
      else $error("unlock not armed for four cycles");
   unlock_end_a: assert property (unlock_q && cnt_q == 2'd0 && !wr_ok |=> !unlock_q)
      else $error("unlock outlived its window");
   // A commit two cycles in, then a retire, may lawfully end the mask in the fourth cycle
   mask_unlock_a: assert property (arm |=> IRQ_MASK [*3])
      else $error("mask dropped during unlock window");
   vsel_guard_a: assert property (wr_ok && !unlock_q |=> $stable(vsel_q))
      else $error("select changed without unlock");
   vsel_commit_a: assert property (commit |=> vsel_q == $past(wr_vsel) && phase_q == PH_HOLD)
      else $error("select commit wrong");
   base_app_a: assert property (!vsel_q && !$past(vsel_q) |-> VECTOR_BASE == `APP_VECTOR_BASE)
      else $error("application vector base wrong");
   hold_release_a: assert property (phase_q == PH_HOLD && INSTR_RETIRE && !arm
                                    |=> phase_q == PH_IDLE)
      else $error("hold not released after next instruction");
   lock_app_a: assert property (vsel_q && !commit && APP_BOOT_LOCK && !EXEC_IN_BOOT
                                |=> IRQ_MASK)
      else $error("application section not blocked");
   lock_boot_a: assert property (!vsel_q && !commit && BOOT_SECTION_LOCK && EXEC_IN_BOOT
                                 |=> IRQ_MASK)
      else $error("boot section not blocked");
   bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   base_boot_a: assert property ($stable(BOOT_SIZE_FUSE) |->
                                 VECTOR_BASE == (vsel_q ? boot_start : `APP_VECTOR_BASE))
      else $error("vector base does not follow fuse");
   reserved_read_a: assert property (ar_take |=> RDATA[31:8] == 24'h000000
                                     && RDATA[3:2] == 2'b00)
      else $error("reserved read bits not zero");
   unlock_read_a: assert property (ar_take && rd_hit |=>
                                   RDATA[`BIT_VEC_UNLOCK] == $past(unlock_q))
      else $error("unlock bit read wrong");
   mask_expire_a: assert property (unlock_q && cnt_q == 2'd0 && !wr_ok && !lock_app_d
                                   && !lock_boot_d |=> !IRQ_MASK)
      else $error("mask outlived unlock window");
   field_write_a: assert property (wr_ok |=>
                                   DEBUG_PORT_DISABLE == w_data_q[`BIT_DEBUG_DIS]
                                   && PULLUP_GLOBAL_DISABLE == w_data_q[`BIT_PULLUP_DIS])
      else $error("writable field not stored");

   // ************************************************************
   // Cover points
   // ************************************************************
   arm_commit_c: cover property (arm ##[1:4] commit);
   arm_expire_c: cover property (arm ##1 (unlock_q && !wr_ok) [*4] ##1 !unlock_q);
   read_c: cover property (ar_take ##1 RVALID && RREADY);
   lock_c: cover property (lock_app_d || lock_boot_d);
   hold_release_c: cover property (phase_q == PH_HOLD && INSTR_RETIRE ##1 !IRQ_MASK);

endmodule // interrupt_vector_select_ctrl

// file: core_model.sv
// Behavioural model of the core: instruction retire pulses and fetch region
`timescale 1ns/1ps

module core_model (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Requests from the bench
   input wire logic RETIRE_REQ,
   input wire logic BOOT_REQ,
   // Core status
   output logic INSTR_RETIRE,
   output logic EXEC_IN_BOOT
);
   always_ff @(posedge CLK) begin
      if (SRST) begin
         INSTR_RETIRE <= 1'b0;
         EXEC_IN_BOOT <= 1'b0;
      end else begin
         // Pulses on alternate cycles while the request lingers; never high two cycles running
         INSTR_RETIRE <= RETIRE_REQ & ~INSTR_RETIRE;
         EXEC_IN_BOOT <= BOOT_REQ;
      end
   end
endmodule // core_model

// file: interrupt_vector_select_ctrl_tb.sv
// Self-checking bench for the system control block
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module interrupt_vector_select_ctrl_tb
   import sysctl_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [11:0] REG_A = {`SYSCTL_INDEX, 2'b00};
   localparam logic [11:0] BAD_A = 12'h0D8;
   logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, fuse;
   logic [15:0] vbase;
   logic retire_req, boot_req, retire, in_boot, app_lock, boot_lock, bod_dis, bod_unl;
   logic irq_mask, dbg_dis, pu_dis;
   logic [15:0] boot_start [4] = '{`BOOT_START_0, `BOOT_START_1, `BOOT_START_2, `BOOT_START_3};
   int n_fail = 0;
   int comparisons = 0;

   interrupt_vector_select_ctrl interrupt_vector_select_ctrl_i (.CLK(clk), .SRST(srst),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
      .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
      .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0),
      .RVALID(rvalid), .RREADY(1'b1), .RDATA(rdata), .RRESP(rresp),
      .INSTR_RETIRE(retire), .EXEC_IN_BOOT(in_boot), .BOOT_SIZE_FUSE(fuse),
      .APP_BOOT_LOCK(app_lock), .BOOT_SECTION_LOCK(boot_lock),
      .BOD_SLEEP_DISABLE_ST(bod_dis), .BOD_SLEEP_UNLOCK_ST(bod_unl),
      .VECTOR_BASE(vbase), .IRQ_MASK(irq_mask), .DEBUG_PORT_DISABLE(dbg_dis),
      .PULLUP_GLOBAL_DISABLE(pu_dis));

   core_model core_model_i (.CLK(clk), .SRST(srst), .RETIRE_REQ(retire_req),
      .BOOT_REQ(boot_req), .INSTR_RETIRE(retire), .EXEC_IN_BOOT(in_boot));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int t;
      logic ad, wd;
      t = 0;
      ad = 1'b0;
      wd = 1'b0;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h0, d};
      while (!(ad && wd) && t < 50) begin
         @(posedge clk);
         t++;
         if (!ad && awready) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && wready) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      while (!bvalid && t < 100) begin
         @(posedge clk);
         t++;
      end
      // Accept one cycle late so the response is seen standing
      chk(bvalid, 1'b1);
      bready <= 1'b1;
      @(posedge clk);
      chk(bresp, er);
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int t;
      t = 0;
      arvalid <= 1'b1;
      araddr <= a;
      do begin
         @(posedge clk);
         t++;
      end while (!arready && t < 50);
      arvalid <= 1'b0;
      while (!rvalid && t < 100) begin
         @(posedge clk);
         t++;
      end
      chk(rvalid, 1'b1);
      chk(rdata, exp);
      chk(rresp, er);
   endtask

   // Unlock, then commit at the next free slot; mask holds until a retire
   task automatic commit(input logic sel);
      axi_wr(REG_A, 8'h01, `RESP_OKAY);
      axi_wr(REG_A, {6'h00, sel, 1'b0}, `RESP_OKAY);
      repeat (6) @(posedge clk);
      chk(irq_mask, 1'b1);
      retire_req <= 1'b1;
      @(posedge clk);
      retire_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk(irq_mask, 1'b0);
   endtask

   task automatic test_done;
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ************************************************************
   // Clock, watchdog and tests
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      test_done();
   end

   initial begin
      {srst, awvalid, wvalid, arvalid, bready, retire_req, boot_req} = 7'b1000000;
      {app_lock, boot_lock, bod_dis, bod_unl} = 4'h0;
      {awaddr, araddr, wdata, fuse} = '0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(vbase, 16'h0000);
      axi_rd(REG_A, 32'h0, `RESP_OKAY);
      bod_dis <= 1'b1;
      bod_unl <= 1'b1;
      axi_wr(REG_A, 8'hFD, `RESP_OKAY);
      chk(irq_mask, 1'b1);
      chk({dbg_dis, pu_dis}, 2'b11);
      repeat (5) @(posedge clk);
      chk(irq_mask, 1'b0);
      axi_rd(REG_A, 32'h000000F0, `RESP_OKAY);
      for (int f = 0; f < 4; f++) begin
         fuse <= f[1:0];
         commit(1'b1);
         chk(vbase, boot_start[f]);
         commit(1'b0);
         chk(vbase, `APP_VECTOR_BASE);
      end
      // A second unlock while armed restarts the window
      axi_wr(REG_A, 8'h01, `RESP_OKAY);
      axi_wr(REG_A, 8'h01, `RESP_OKAY);
      axi_rd(REG_A, 32'h00000061, `RESP_OKAY);
      axi_wr(REG_A, 8'h02, `RESP_OKAY);
      repeat (3) @(posedge clk);
      chk({irq_mask, vbase}, 17'h0);
      commit(1'b1);
      app_lock <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq_mask, 1'b1);
      boot_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq_mask, 1'b0);
      commit(1'b0);
      boot_lock <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq_mask, 1'b1);
      boot_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk(irq_mask, 1'b0);
      axi_wr(BAD_A, 8'hFF, `RESP_SLVERR);
      chk({irq_mask, dbg_dis}, 2'b00);
      axi_rd(BAD_A, 32'h0, `RESP_SLVERR);
      axi_wr(REG_A, 8'h90, `RESP_OKAY);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      axi_rd(REG_A, 32'h00000060, `RESP_OKAY);
      test_done();
   end
endmodule // interrupt_vector_select_ctrl_tb
